// file: verif/lvdm_far_model.sv
/*
  Far side of the monitor: analog supply comparator and cpu vector logic.
  Assumes the bench sets supplyMv and that mclk is the monitor clock.
*/
`timescale 1ns/1ps
module lvdm_far_model #(
  parameter int ACK_WAIT = 4
) (
  input wire logic mclk, // monitor clock
  input wire logic reset, // synchronous, active high
  input wire logic [15:0] supplyMv, // simulated supply in millivolts
  input wire logic detectorPowerEn, // detector power from the block
  input wire logic [2:0] thresholdCode, // selected trip level
  input wire logic groupVectorReq, // group vector request
  output logic cmpLowRaw, // comparator, high while supply is low
  output logic irqServiceAck = 1'b0 // cpu took the vector
);
  int lvlMv[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
  int waitCnt = 0;
  ////////////////////////////////////////////////////////////////////////////
  // comparator trips only while powered
  assign cmpLowRaw = detectorPowerEn && (supplyMv < lvlMv[thresholdCode]);
  ////////////////////////////////////////////////////////////////////////////
  // cpu takes the vector late, acks once; a slow cpu is legal
  always @(posedge mclk)
  begin
    if (reset || groupVectorReq !== 1'b1 || irqServiceAck)
    begin
      waitCnt <= 0;
      irqServiceAck <= 1'b0;
    end
    else if (waitCnt == ACK_WAIT)
      irqServiceAck <= 1'b1;
    else
      waitCnt <= waitCnt + 1;
  end
endmodule : lvdm_far_model

// file: verif/tb_top.sv
/*
  Self-checking bench for the low voltage detect monitor.
  Assumes lvdm_defs.svh for offsets and the far model for the comparator.
*/
`timescale 1ns/1ps
`include "lvdm_defs.svh"
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmpLowRaw, irqServiceAck, detectorPowerEn;
  logic groupVectorReq, wakeUp, irq;
  logic [2:0] thresholdCode;
  logic [15:0] supplyMv = 16'h1388;
  int numErrors = 0;
  int nCompared = 0;
  int lvl[8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};
  always #5 mclk = ~mclk;
  lvdm_monitor i_lvdm_monitor (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmpLowRaw(cmpLowRaw), .irqServiceAck(irqServiceAck),
    .detectorPowerEn(detectorPowerEn), .thresholdCode(thresholdCode),
    .groupVectorReq(groupVectorReq), .wakeUp(wakeUp), .irq(irq));
  lvdm_far_model i_lvdm_far_model (.mclk(mclk), .reset(reset), .supplyMv(supplyMv),
    .detectorPowerEn(detectorPowerEn), .thresholdCode(thresholdCode),
    .groupVectorReq(groupVectorReq), .cmpLowRaw(cmpLowRaw), .irqServiceAck(irqServiceAck));
  ////////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task automatic endSim;
    $display("errors=%0d compared=%0d", numErrors, nCompared);
    if (numErrors == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : endSim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      numErrors++;
    end
  endtask : chk
  // one apb transfer; waits for pready without a bound, no assumed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  // clear request flags and pending status
  task automatic clr;
    logic [31:0] r;
    logic e;
    wr(`LVDM_ADDR_FLAGS, 32'h0);
    apb(1'b0, `LVDM_ADDR_STAT, 32'h0, r, e);
  endtask : clr
  // cycles until wakeUp, bounded
  task automatic waitWake(input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wakeUp !== 1'b1 && n < lim);
  endtask : waitWake
  ////////////////////////////////////////////////////////////////////////////
  task automatic tReset;
    rd(`LVDM_ADDR_CTRL, 32'h0, 1'b0);
    rd(`LVDM_ADDR_IEN, 32'h0, 1'b0);
    rd(`LVDM_ADDR_FLAGS, 32'h0, 1'b0);
    rd(`LVDM_ADDR_STAT, 32'h0, 1'b0);
    rd(`LVDM_ADDR_MASK, 32'h0, 1'b0);
    rd(8'h14, 32'h0, 1'b1);
  endtask : tReset
  task automatic tCtrl;
    wr(`LVDM_ADDR_CTRL, 32'hff);
    rd(`LVDM_ADDR_CTRL, 32'h17, 1'b0);
    chk({28'h0, detectorPowerEn, thresholdCode}, 32'hf);
    supplyMv <= 16'h0c1c;
    for (int c = 0; c < 8; c++)
    begin
      wr(`LVDM_ADDR_CTRL, 32'h10 | c);
      repeat (5) @(posedge mclk);
      rd(`LVDM_ADDR_CTRL, (32'h10 | c) | ((lvl[c] > 3100) ? 32'h20 : 32'h0), 1'b0);
    end
    wr(`LVDM_ADDR_CTRL, 32'h07);
    rd(`LVDM_ADDR_CTRL, 32'h07, 1'b0);
    chk({31'h0, detectorPowerEn}, 32'h0);
  endtask : tCtrl
  task automatic tDelay;
    int n;
    int w0;
    supplyMv <= 16'h1388;
    wr(`LVDM_ADDR_CTRL, 32'h10);
    repeat (5) @(posedge mclk);
    clr;
    wr(`LVDM_ADDR_MASK, 32'h7);
    wr(`LVDM_ADDR_IEN, 32'h7);
    @(posedge mclk);
    supplyMv <= 16'h076c;
    waitWake(50, n);
    chk({31'h0, wakeUp}, 32'h0);
    supplyMv <= 16'h1388;
    repeat (5) @(posedge mclk);
    supplyMv <= 16'h076c;
    waitWake(200, n);
    chk({31'h0, (n >= 104 && n <= 106)}, 32'h1);
    w0 = 0;
    while (groupVectorReq !== 1'b1 && w0 < 5)
    begin
      @(posedge mclk);
      w0++;
    end
    chk({31'h0, groupVectorReq}, 32'h1);
    repeat (12) @(posedge mclk);
    chk({31'h0, groupVectorReq}, 32'h0);
    rd(`LVDM_ADDR_IEN, 32'h3, 1'b0);
    rd(`LVDM_ADDR_FLAGS, 32'h1, 1'b0);
    chk({31'h0, irq}, 32'h1);
    rd(`LVDM_ADDR_STAT, 32'h7, 1'b0);
    rd(`LVDM_ADDR_STAT, 32'h0, 1'b0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(`LVDM_ADDR_IEN, 32'h0);
    rd(`LVDM_ADDR_FLAGS, 32'h1, 1'b0);
  endtask : tDelay
  task automatic tWake;
    int n;
    logic [31:0] r;
    logic e;
    supplyMv <= 16'h1388;
    repeat (5) @(posedge mclk);
    clr;
    wr(`LVDM_ADDR_MASK, 32'h0);
    wr(`LVDM_ADDR_FLAGS, 32'h1);
    waitWake(5, n);
    chk({31'h0, wakeUp}, 32'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(`LVDM_ADDR_MASK, 32'h4);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `LVDM_ADDR_STAT, 32'h0, r, e);
    chk({31'h0, r[`LVDM_ST_WAKE_BIT]}, 32'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    // preset flag blocks the wake edge
    supplyMv <= 16'h076c;
    waitWake(150, n);
    chk({31'h0, wakeUp}, 32'h0);
  endtask : tWake
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    tReset;
    tCtrl;
    tDelay;
    tWake;
    endSim;
  end
  // watchdog: whole run needs well under 3000 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    endSim;
  end
endmodule : tb_top

// file: verilog/lvdm_defs.svh
/*
  Constants for the low voltage detect monitor: register offsets,
  field positions, reset values and timing counts.
  Assumes it is included by bare name from the design files and the bench.
*/
`ifndef LVDM_DEFS_SVH
`define LVDM_DEFS_SVH

// byte offsets on the register bus
`define LVDM_ADDR_W 8
`define LVDM_ADDR_CTRL 8'h00
`define LVDM_ADDR_IEN 8'h04
`define LVDM_ADDR_FLAGS 8'h08
`define LVDM_ADDR_STAT 8'h0c
`define LVDM_ADDR_MASK 8'h10

// lvd_control fields
`define LVDM_CTRL_SEL_HI 2
`define LVDM_CTRL_SEL_LO 0
`define LVDM_CTRL_EN_BIT 4
`define LVDM_CTRL_FLAG_BIT 5
`define LVDM_RST_SEL 3'h0
`define LVDM_RST_BIT 1'b0

// interrupt enable fields
`define LVDM_IEN_LVD_BIT 0
`define LVDM_IEN_GRP_BIT 1
`define LVDM_IEN_GLB_BIT 2

// request flag fields
`define LVDM_FLG_LVD_BIT 0
`define LVDM_FLG_GRP_BIT 1

// event status and mask fields
`define LVDM_ST_W 3
`define LVDM_ST_LOW_BIT 0
`define LVDM_ST_REQ_BIT 1
`define LVDM_ST_WAKE_BIT 2
`define LVDM_RST_ST 3'h0

// timing
`define LVDM_CLK_PERIOD_NS 10
`define LVDM_IRQ_DELAY_NS 1000
`define LVDM_IRQ_DELAY_CYC \
  ((`LVDM_IRQ_DELAY_NS + `LVDM_CLK_PERIOD_NS - 1) / `LVDM_CLK_PERIOD_NS)
`define LVDM_CNT_W 8

`endif

// file: verilog/lvdm_monitor.sv
/*
  Low voltage detect monitor: control register, comparator sync, delayed
  request flag, grouped interrupt request, wake-up edge and an event
  interrupt unit, all behind an APB slave.
  Assumes mclk is the always-on monitor clock and cmpLowRaw comes
  straight from the analog comparator (high while supply is low).
*/
// Our own choices: the address map and the APB slave port.
// How it works
// R1: enable bit powers detector on or off
// R2: three-bit code selects one of eight levels
// R3: flag bit reads one while supply low
// R4: unused control bits read zero, ignore writes
// R5: detector keeps running in low-power modes
// R6: software waits settle time before trusting flag
// R7: flag may chatter; logic tolerates repeated edges
// R8: request set only after delay of low flag
// R9: request routed through the shared group request
// R10: any request rising edge wakes the device
// R11: wake edge logic runs on always-on clock
// R12: software presets flag high to block wake
// R13: set request holds until serviced or cleared
// R14: service clears group flag; software clears source
// R15: software clears flag before enabling interrupt
// R16: global and source enables needed for vector
// R17: servicing clears global enable, blocking interrupts
// R18: comparator passes two-stage synchroniser first
// R19: delay counter restarts when supply recovers
`timescale 1ns/1ps
`include "lvdm_defs.svh"
module lvdm_monitor (
  input wire logic mclk, // monitor clock, 100 MHz
  input wire logic reset, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [`LVDM_ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic cmpLowRaw, // async comparator, high = supply low
  input wire logic irqServiceAck, // cpu takes the group vector
  output logic detectorPowerEn, // powers detector and reference
  output logic [2:0] thresholdCode, // trip level to the reference
  output logic groupVectorReq, // group vector request to the cpu
  output logic wakeUp, // wake pulse, one cycle per request flag edge
  output logic irq // level event interrupt
);

  localparam logic [`LVDM_CNT_W-1:0] DLY_LAST =
    `LVDM_CNT_W'(`LVDM_IRQ_DELAY_CYC - 1);

  lvdm_pkg::lvdm_reg_e regSel;
  logic syncLow;
  logic lowVoltageFlag;
  logic lowPrev;
  logic [`LVDM_CNT_W-1:0] delayCount;
  logic delayDone;
  logic hwSet;
  logic lvdIrqRequest;
  logic lvdPrev;
  logic groupIrqRequest;
  logic grpPrev;
  logic lvdIrqEnable;
  logic groupIrqEnable;
  logic globalIrqEnable;
  logic [`LVDM_ST_W-1:0] status;
  logic [`LVDM_ST_W-1:0] mask;
  logic [`LVDM_ST_W-1:0] events;
  logic [31:0] next_rdata;
  logic accessCycle;
  logic fire;
  logic wrCtrl;
  logic wrIen;
  logic wrFlags;
  logic wrMask;
  logic rdStat;
  logic lvdRise;
  logic grpRise;
  logic grpSet;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  // address decode
  always_comb
  begin
    if (paddr == `LVDM_ADDR_CTRL)
      regSel = lvdm_pkg::REG_CTRL;
    else if (paddr == `LVDM_ADDR_IEN)
      regSel = lvdm_pkg::REG_IEN;
    else if (paddr == `LVDM_ADDR_FLAGS)
      regSel = lvdm_pkg::REG_FLAGS;
    else if (paddr == `LVDM_ADDR_STAT)
      regSel = lvdm_pkg::REG_STAT;
    else if (paddr == `LVDM_ADDR_MASK)
      regSel = lvdm_pkg::REG_MASK;
    else
      regSel = lvdm_pkg::REG_NONE;
  end

  // one wait state so that every bus output comes from a flop
  assign accessCycle = psel && penable && !pready;
  assign fire = psel && penable && pready;
  assign wrCtrl = fire && pwrite && (regSel == lvdm_pkg::REG_CTRL);
  assign wrIen = fire && pwrite && (regSel == lvdm_pkg::REG_IEN);
  assign wrFlags = fire && pwrite && (regSel == lvdm_pkg::REG_FLAGS);
  assign wrMask = fire && pwrite && (regSel == lvdm_pkg::REG_MASK);
  assign rdStat = fire && !pwrite && (regSel == lvdm_pkg::REG_STAT);

  // read mux; unused bits stay zero
  always_comb
  begin
    next_rdata = '0;
    case (regSel)
      lvdm_pkg::REG_CTRL:
      begin
        // R4 unused bits zero
        next_rdata[`LVDM_CTRL_SEL_HI:`LVDM_CTRL_SEL_LO] = thresholdCode;
        next_rdata[`LVDM_CTRL_EN_BIT] = detectorPowerEn;
        // R3 flag readback
        next_rdata[`LVDM_CTRL_FLAG_BIT] = lowVoltageFlag;
      end
      lvdm_pkg::REG_IEN:
      begin
        next_rdata[`LVDM_IEN_LVD_BIT] = lvdIrqEnable;
        next_rdata[`LVDM_IEN_GRP_BIT] = groupIrqEnable;
        next_rdata[`LVDM_IEN_GLB_BIT] = globalIrqEnable;
      end
      lvdm_pkg::REG_FLAGS:
      begin
        next_rdata[`LVDM_FLG_LVD_BIT] = lvdIrqRequest;
        next_rdata[`LVDM_FLG_GRP_BIT] = groupIrqRequest;
      end
      lvdm_pkg::REG_STAT: next_rdata[`LVDM_ST_W-1:0] = status;
      lvdm_pkg::REG_MASK: next_rdata[`LVDM_ST_W-1:0] = mask;
      default: next_rdata = '0;
    endcase
  end

  // bus answer flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= accessCycle;
      pslverr <= accessCycle && (regSel == lvdm_pkg::REG_NONE);
      if (accessCycle && !pwrite)
        prdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  // R1 detector power switch
  // R5 never gated by sleep: the enable alone keeps it running
  // R2 trip level select
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      detectorPowerEn <= `LVDM_RST_BIT;
      thresholdCode <= `LVDM_RST_SEL;
    end
    else if (wrCtrl)
    begin
      detectorPowerEn <= pwdata[`LVDM_CTRL_EN_BIT];
      thresholdCode <= pwdata[`LVDM_CTRL_SEL_HI:`LVDM_CTRL_SEL_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator path and delay

  // R18 two-stage synchroniser
  lvdm_sync #(
    .W(1)
  ) u_sync (
    .mclk(mclk),
    .reset(reset),
    .async(cmpLowRaw),
    .synced(syncLow)
  );

  // R3 flag follows the synced comparator; an off detector reads no low
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lowVoltageFlag <= `LVDM_RST_BIT;
      lowPrev <= `LVDM_RST_BIT;
    end
    else
    begin
      lowVoltageFlag <= detectorPowerEn && syncLow;
      lowPrev <= lowVoltageFlag;
    end
  end

  // R19 restart on recovery
  // R7 each new low episode counts afresh, chatter just restarts it
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      delayCount <= '0;
      delayDone <= `LVDM_RST_BIT;
    end
    else if (!lowVoltageFlag)
    begin
      delayCount <= '0;
      delayDone <= `LVDM_RST_BIT;
    end
    else if (!delayDone)
    begin
      delayCount <= delayCount + `LVDM_CNT_W'(1);
      delayDone <= (delayCount == DLY_LAST);
    end
  end

  // R8 request only once the delay has run out
  assign hwSet = lowVoltageFlag && !delayDone && (delayCount == DLY_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // request flags and enables

  // R13 flag holds; set wins over a software clear in the same cycle
  // R12 software may also write it high to mask a later wake edge
  always_ff @(posedge mclk)
  begin
    if (reset)
      lvdIrqRequest <= `LVDM_RST_BIT;
    else if (hwSet)
      lvdIrqRequest <= 1'b1;
    else if (wrFlags)
      lvdIrqRequest <= pwdata[`LVDM_FLG_LVD_BIT];
  end

  // R9 detector request feeds the shared group flag
  // R16 the source enable gates it into the group
  assign lvdRise = lvdIrqRequest && !lvdPrev;
  assign grpSet = lvdRise && lvdIrqEnable;

  // R14 service clears only the group flag, never the source flag
  always_ff @(posedge mclk)
  begin
    if (reset)
      groupIrqRequest <= `LVDM_RST_BIT;
    else if (grpSet)
      groupIrqRequest <= 1'b1;
    else if (irqServiceAck)
      groupIrqRequest <= 1'b0;
    else if (wrFlags)
      groupIrqRequest <= pwdata[`LVDM_FLG_GRP_BIT];
  end

  // enable bits; R17 service drops the global enable
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lvdIrqEnable <= `LVDM_RST_BIT;
      groupIrqEnable <= `LVDM_RST_BIT;
      globalIrqEnable <= `LVDM_RST_BIT;
    end
    else
    begin
      if (wrIen)
      begin
        lvdIrqEnable <= pwdata[`LVDM_IEN_LVD_BIT];
        groupIrqEnable <= pwdata[`LVDM_IEN_GRP_BIT];
      end
      // R17 clear global enable
      if (irqServiceAck)
        globalIrqEnable <= 1'b0;
      else if (wrIen)
        globalIrqEnable <= pwdata[`LVDM_IEN_GLB_BIT];
    end
  end

  // R16 vector needs global and group enable with a pending group flag
  always_ff @(posedge mclk)
  begin
    if (reset)
      groupVectorReq <= `LVDM_RST_BIT;
    else
      groupVectorReq <= globalIrqEnable && groupIrqEnable && groupIrqRequest;
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake-up

  // R10 any flag rising edge wakes, whatever the enables
  // R11 mclk is the always-on clock, so this works with the cpu stopped
  assign grpRise = groupIrqRequest && !grpPrev;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lvdPrev <= `LVDM_RST_BIT;
      grpPrev <= `LVDM_RST_BIT;
      wakeUp <= `LVDM_RST_BIT;
    end
    else
    begin
      lvdPrev <= lvdIrqRequest;
      grpPrev <= groupIrqRequest;
      wakeUp <= lvdRise || grpRise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event interrupt unit

  // R7 every flag rise is an event, so chatter may post it again
  always_comb
  begin
    events = '0;
    events[`LVDM_ST_LOW_BIT] = lowVoltageFlag && !lowPrev;
    events[`LVDM_ST_REQ_BIT] = hwSet;
    events[`LVDM_ST_WAKE_BIT] = lvdRise || grpRise;
  end

  // read clears only the bits that reached the bus, so a late set survives
  always_ff @(posedge mclk)
  begin
    if (reset)
      status <= `LVDM_RST_ST;
    else if (rdStat)
      status <= (status & ~prdata[`LVDM_ST_W-1:0]) | events;
    else
      status <= status | events;
  end

  // mask register and interrupt line
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      mask <= `LVDM_RST_ST;
      irq <= `LVDM_RST_BIT;
    end
    else
    begin
      if (wrMask)
        mask <= pwdata[`LVDM_ST_W-1:0];
      irq <= |(status & mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam int A_LAST = `LVDM_IRQ_DELAY_CYC - 1;
  logic [`LVDM_CNT_W-1:0] flagRun;

  // helper: consecutive cycles the flag has been high, saturating
  always_ff @(posedge mclk)
  begin
    if (reset || !lowVoltageFlag)
      flagRun <= '0;
    else if (flagRun != '1)
      flagRun <= flagRun + `LVDM_CNT_W'(1);
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_low_held;
    (cmpLowRaw && detectorPowerEn) [*4];
  endsequence
  sequence s_high_held;
    (!cmpLowRaw) [*4];
  endsequence

  a_power_write: assert property (wrCtrl |=> // R1
    detectorPowerEn == $past(pwdata[`LVDM_CTRL_EN_BIT]))
    else $error("detector power did not follow write");
  a_level_write: assert property (wrCtrl |=> // R2
    thresholdCode == $past(pwdata[`LVDM_CTRL_SEL_HI:`LVDM_CTRL_SEL_LO]))
    else $error("threshold code did not follow write");
  a_flag_low: assert property (s_low_held |-> lowVoltageFlag) // R18
    else $error("flag missed a held low supply");
  a_flag_high: assert property (s_high_held |-> !lowVoltageFlag) // R3
    else $error("flag set while supply above level");
  a_reserved_zero: assert property (fire && !pwrite && // R4
    regSel == lvdm_pkg::REG_CTRL |-> prdata[7:6] == 2'b00 && !prdata[3])
    else $error("unused control bits read non-zero");
  a_delay_irq: assert property ($rose(lvdIrqRequest) && // R8
    !$past(wrFlags) |-> $past(flagRun) == A_LAST)
    else $error("request set before delay elapsed");
  a_delay_restart: assert property (!lowVoltageFlag |=> // R19
    delayCount == '0)
    else $error("delay counter not restarted");
  a_wake_edge: assert property ($rose(lvdIrqRequest) |=> wakeUp) // R10
    else $error("request edge gave no wake pulse");
  a_flag_holds: assert property (lvdIrqRequest && !wrFlags |=> // R13
    lvdIrqRequest)
    else $error("request flag dropped on its own");
  a_service_clear: assert property (irqServiceAck && !grpSet |=> // R17
    !groupIrqRequest && !globalIrqEnable)
    else $error("service did not clear group flag and global enable");
  a_source_kept: assert property (irqServiceAck && lvdIrqRequest && // R14
    !wrFlags |=> lvdIrqRequest)
    else $error("service cleared the source flag");
  a_vector_gate: assert property (groupVectorReq |-> // R16
    $past(globalIrqEnable && groupIrqEnable && groupIrqRequest))
    else $error("vector raised without enables");

endmodule : lvdm_monitor

// file: verilog/lvdm_pkg.sv
/*
  Types for the low voltage detect monitor.
  Assumes lvdm_defs.svh holds all numeric constants.
*/
package lvdm_pkg;

  // register selected by the current bus address
  typedef enum logic [2:0] {
    REG_CTRL,
    REG_IEN,
    REG_FLAGS,
    REG_STAT,
    REG_MASK,
    REG_NONE
  } lvdm_reg_e;

  // trip level codes, lowest to highest supply threshold
  typedef enum logic [2:0] {
    LVL_2V0,
    LVL_2V2,
    LVL_2V4,
    LVL_2V7,
    LVL_3V0,
    LVL_3V3,
    LVL_3V6,
    LVL_4V0
  } lvdm_level_e;

endpackage : lvdm_pkg

// file: verilog/lvdm_sync.sv
/*
  Two flip-flop synchroniser for asynchronous levels.
  Assumes the input is a slow level; pulses shorter than a clock may be lost.
*/
`timescale 1ns/1ps
module lvdm_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // monitor clock
  input wire logic reset, // synchronous, active high
  input wire logic [W-1:0] async, // level from another domain
  output logic [W-1:0] synced // level safe to use on mclk
);

  logic [W-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      stage1 <= '0;
      synced <= '0;
    end
    else
    begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : lvdm_sync
